/* core/drm_pkg.sv */
// shared constants and types for the data-rate measurement block
package drm_pkg;

  localparam int REG_W            = 8;
  localparam int COUNT_W          = 23;
  localparam int COUNT_HIGH_W     = 7;
  localparam int COUNT_BYTE_W     = 8;
  localparam int COARSE_W         = 9;
  localparam int RANGE_W          = 2;

  // reference window is 2^(base + range) reference cycles
  localparam int WIN_BASE_LOG2_DEF = 14;
  localparam int REC_CNT_W_DEF     = 24;

  // action and output configuration bit positions
  localparam int ACT_MEAS_RESTART_BIT = 3;
  localparam int ACT_ACQ_RESTART_BIT  = 5;
  localparam int OCFG_LOS_POL_BIT     = 2;

  // auxiliary status bit positions
  localparam int AUX_COARSE_LSB_BIT = 0;
  localparam int AUX_DONE_BIT       = 2;

  // values after reset
  localparam logic [RANGE_W-1:0] RANGE_RST     = 2'h0;
  localparam logic [COUNT_W-1:0] COUNT_RST     = 23'h00_0000;
  localparam logic [COARSE_W-1:0] COARSE_RST   = 9'h000;
  localparam logic [REG_W-1:0]   AUX_RST       = 8'h00;

  typedef struct packed {
    logic [RANGE_W-1:0] range_sel;
    logic [3:0]         lock_ratio;
    logic               fine_en;
    logic               lock_ref_en;
  } drm_rate_cfg_t;

  typedef struct packed {
    logic [COUNT_HIGH_W-1:0] high;
    logic [COUNT_BYTE_W-1:0] middle;
    logic [COUNT_BYTE_W-1:0] low;
  } drm_count_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_RUN,
    ST_DONE
  } drm_state_t;

endpackage

/* core/drm_sync2.sv */
// two-flop synchroniser for levels and gray-coded words
`timescale 1ns/100ps
module drm_sync2
  import drm_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule

/* core/drm_rec_counter.sv */
// free-running gray edge counter in the recovered clock domain
`timescale 1ns/100ps
module drm_rec_counter
  import drm_pkg::*;
#(
  parameter int W = REC_CNT_W_DEF
) (
  input  wire logic         rec_clk_in,
  input  wire logic         rst_n_in,
  output logic      [W-1:0] gray_out
);

  logic         rst_meta;
  logic         rst_ok;
  logic [W-1:0] bin;
  logic [W-1:0] next_bin;

  // reset asserts at once, releases on this clock
  always_ff @(posedge rec_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_ok   <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_ok   <= rst_meta;
    end
  end

  assign next_bin = bin + W'(1);

  always_ff @(posedge rec_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bin      <= '0;
      gray_out <= '0;
    end else if (rst_ok) begin
      bin      <= next_bin;
      gray_out <= next_bin ^ (next_bin >> 1);
    end
  end

endmodule

/* core/drm_ctrl.sv */
// data-rate measurement, coarse rate, loss-of-signal and re-acquisition control
`timescale 1ns/100ps
// Notes on behaviour
// - count recovered edges over reference window
// - range field sets window, default lowest band
// - measurement never disturbs lock acquisition
// - fine enable is a held level
// - one-then-zero restart clears done, measures
// - done low while measuring, high when valid
// - count split high, middle, low bytes
// - coarse code from rate and aux bit
// - polarity bit inverts loss-of-signal output
// - one-then-zero restarts acquisition, keeps settings
module drm_ctrl
  import drm_pkg::*;
#(
  parameter int WIN_BASE_LOG2 = WIN_BASE_LOG2_DEF,
  parameter int REC_CNT_W     = REC_CNT_W_DEF
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             rec_clk_in,
  input  wire logic [REG_W-1:0] rate_config_reg_in,
  input  wire logic [REG_W-1:0] action_reg_in,
  input  wire logic [REG_W-1:0] output_config_reg_in,
  input  wire logic             lock_lost_in,
  input  wire logic [REG_W-1:0] rate_code_in,
  input  wire logic             rate_code_lsb_in,
  input  wire logic             signal_absent_det_in,
  output logic                  meas_done_out,
  output drm_count_t            rate_count_out,
  output logic                  rate_valid_out,
  output logic [COARSE_W-1:0]   coarse_code_out,
  output logic                  coarse_valid_out,
  output logic [REG_W-1:0]      aux_status_out,
  output logic                  signal_absent_out,
  output logic                  acq_restart_out
);

  localparam int WIN_W = WIN_BASE_LOG2 + 4;

  drm_rate_cfg_t        cfg;
  drm_state_t           state;
  drm_state_t           next_state;
  logic                 act_meas_q;
  logic                 act_acq_q;
  logic                 meas_restart;
  logic                 acq_fall;
  logic [REC_CNT_W-1:0] rec_gray;
  logic [REC_CNT_W-1:0] rec_gray_s;
  logic [REC_CNT_W-1:0] rec_bin;
  logic [REC_CNT_W-1:0] start_snap;
  logic [REC_CNT_W-1:0] span;
  logic [WIN_W-1:0]     win_cnt;
  logic [COUNT_W-1:0]   result;
  logic                 win_end;
  logic                 los_s;

  function automatic logic [REC_CNT_W-1:0] gray2bin(input logic [REC_CNT_W-1:0] g);
    logic [REC_CNT_W-1:0] b;
    b = g;
    for (int i = REC_CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // last count value of a window of 2^(base + range) cycles
  function automatic logic [WIN_W-1:0] win_load(input logic [RANGE_W-1:0] sel);
    logic [63:0] len;
    len = 64'd1 << (WIN_BASE_LOG2 + int'(sel));
    return WIN_W'(len - 64'd1);
  endfunction

  assign cfg = drm_rate_cfg_t'(rate_config_reg_in);

  // recovered-clock side and its crossing
  drm_rec_counter #(
    .W (REC_CNT_W)
  ) u_rec_counter (
    .rec_clk_in (rec_clk_in),
    .rst_n_in   (rst_n_in),
    .gray_out   (rec_gray)
  );

  drm_sync2 #(
    .W (REC_CNT_W)
  ) u_rec_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (rec_gray),
    .q_out    (rec_gray_s)
  );

  drm_sync2 #(
    .W (1)
  ) u_los_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (signal_absent_det_in),
    .q_out    (los_s)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rec_bin <= '0;
    end else begin
      rec_bin <= gray2bin(rec_gray_s);
    end
  end

  // write-one-then-zero detection on the action bits
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_meas_q <= 1'b0;
      act_acq_q  <= 1'b0;
    end else begin
      act_meas_q <= action_reg_in[ACT_MEAS_RESTART_BIT];
      act_acq_q  <= action_reg_in[ACT_ACQ_RESTART_BIT];
    end
  end

  assign meas_restart = act_meas_q && !action_reg_in[ACT_MEAS_RESTART_BIT];
  assign acq_fall     = act_acq_q && !action_reg_in[ACT_ACQ_RESTART_BIT];

  // acquisition restart depends on the action bit alone
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acq_restart_out <= 1'b0;
    end else begin
      acq_restart_out <= acq_fall;
    end
  end

  // measurement sequencer
  assign win_end = (state == ST_RUN) && (win_cnt == '0);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_ARM: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (win_cnt == '0) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!cfg.fine_en) begin
      next_state = ST_IDLE;
    end else if (meas_restart) begin
      next_state = ST_ARM;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // reference window length latched at start
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      win_cnt <= '0;
    end else if (state == ST_ARM) begin
      win_cnt <= win_load(cfg.range_sel);
    end else if (state == ST_RUN && win_cnt != '0) begin
      win_cnt <= win_cnt - WIN_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_snap <= '0;
    end else if (state == ST_ARM) begin
      start_snap <= rec_bin;
    end
  end

  assign span = rec_bin - start_snap;

  // result and done flag; a restart beats a coinciding completion
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result <= COUNT_RST;
    end else if (win_end && next_state == ST_DONE) begin
      result <= span[COUNT_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meas_done_out <= 1'b0;
    end else if (meas_restart) begin
      meas_done_out <= 1'b0;
    end else if (win_end && next_state == ST_DONE) begin
      meas_done_out <= 1'b1;
    end
  end

  assign rate_count_out = drm_count_t'(result);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rate_valid_out <= 1'b0;
    end else begin
      rate_valid_out <= meas_done_out && !lock_lost_in;
    end
  end

  // coarse rate code, refreshed only while locked
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      coarse_code_out  <= COARSE_RST;
      coarse_valid_out <= 1'b0;
    end else begin
      coarse_valid_out <= !lock_lost_in;
      if (!lock_lost_in) begin
        coarse_code_out <= {rate_code_in, rate_code_lsb_in};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aux_status_out <= AUX_RST;
    end else begin
      aux_status_out                     <= AUX_RST;
      aux_status_out[AUX_COARSE_LSB_BIT] <= rate_code_lsb_in;
      aux_status_out[AUX_DONE_BIT]       <= meas_done_out;
    end
  end

  // loss-of-signal output polarity
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      signal_absent_out <= 1'b0;
    end else begin
      signal_absent_out <= los_s ^ output_config_reg_in[OCFG_LOS_POL_BIT];
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking

  default disable iff (!rst_n_in);

  restart_clears_a: assert property (
    (meas_restart && cfg.fine_en) |=> (!meas_done_out && state == ST_ARM)
      ##1 (state == ST_RUN || !$past(cfg.fine_en))
  ) else $error("restart did not clear done and start");

  done_at_end_a: assert property (
    $rose(meas_done_out) |-> $past(win_end)
  ) else $error("done rose without window end");

  done_low_run_a: assert property (
    (state == ST_ARM || state == ST_RUN) |-> !meas_done_out
  ) else $error("done high while measuring");

  window_len_a: assert property (
    (state == ST_ARM) |=> (win_cnt == win_load($past(cfg.range_sel)))
  ) else $error("window length does not follow range");

  count_value_a: assert property (
    $rose(meas_done_out) |-> (result == $past(span[COUNT_W-1:0]))
  ) else $error("count is not edges over window");

  count_split_a: assert property (
    (rate_count_out.high == result[22:16]) && (rate_count_out.middle == result[15:8])
      && (rate_count_out.low == result[7:0])
  ) else $error("count bytes misplaced");

  result_hold_a: assert property (
    (meas_done_out && !meas_restart) |=> $stable(result) && meas_done_out
  ) else $error("result moved before restart");

  enable_level_a: assert property (
    (!cfg.fine_en) |=> (state == ST_IDLE)
  ) else $error("measurement ran without enable");

  acq_pulse_a: assert property (
    acq_fall |=> acq_restart_out ##1 (!acq_restart_out || $past(acq_fall))
  ) else $error("acquisition restart pulse wrong");

  acq_indep_a: assert property (
    (meas_restart && !acq_fall) |=> !acq_restart_out
  ) else $error("measurement restart disturbed acquisition");

  coarse_hold_a: assert property (
    lock_lost_in |=> $stable(coarse_code_out) && !coarse_valid_out
  ) else $error("coarse code changed during lock loss");

  los_polarity_a: assert property (
    ##1 (signal_absent_out == ($past(los_s) ^ $past(output_config_reg_in[OCFG_LOS_POL_BIT])))
  ) else $error("loss-of-signal polarity wrong");

  arm_after_restart_a: assert property (
    (state == ST_ARM) |-> ($past(meas_restart) && $past(cfg.fine_en))
  ) else $error("measurement armed without restart");

  snap_at_arm_a: assert property (
    (state == ST_ARM) |=> (start_snap == $past(rec_bin))
  ) else $error("window start snapshot missed");

  window_count_a: assert property (
    (state == ST_RUN && win_cnt != '0) |=> (win_cnt == $past(win_cnt) - WIN_W'(1))
  ) else $error("window counter did not step");

  acq_only_fall_a: assert property (
    (!acq_fall) |=> !acq_restart_out
  ) else $error("acquisition restart without one-then-zero");

  coarse_follow_a: assert property (
    (!lock_lost_in) |=> coarse_valid_out
      && (coarse_code_out == {$past(rate_code_in), $past(rate_code_lsb_in)})
  ) else $error("coarse code not refreshed while locked");

  aux_bits_a: assert property (
    ##1 ((aux_status_out[AUX_COARSE_LSB_BIT] == $past(rate_code_lsb_in))
      && (aux_status_out[AUX_DONE_BIT] == $past(meas_done_out)))
  ) else $error("auxiliary status bits wrong");

  valid_follows_a: assert property (
    ##1 (rate_valid_out == ($past(meas_done_out) && !$past(lock_lost_in)))
  ) else $error("rate valid does not follow done and lock");

  idle_keeps_done_a: assert property (
    (state == ST_IDLE && !meas_restart) |=> ($stable(meas_done_out) && $stable(result))
  ) else $error("done or result moved while idle");

endmodule

/* tb/drm_host_model.sv */
// host model owning the three control registers
`timescale 1ns/100ps
module drm_host_model
  import drm_pkg::*;
(
  input  wire logic             clk_in,
  output logic      [REG_W-1:0] rate_cfg_out,
  output logic      [REG_W-1:0] action_out,
  output logic      [REG_W-1:0] out_cfg_out
);
  initial begin
    rate_cfg_out = 8'h00;
    action_out = 8'h00;
    out_cfg_out = 8'h00;
  end
  // lock-to-reference bit always left clear
  task automatic set_cfg(input logic [RANGE_W-1:0] r, input logic fine);
    @(posedge clk_in);
    #1 rate_cfg_out = {r, 4'h0, fine, 1'b0};
  endtask
  // one-then-zero on an action bit
  task automatic pulse(input int b);
    @(posedge clk_in);
    #1 action_out[b] = 1'b1;
    @(posedge clk_in);
    #1 action_out[b] = 1'b0;
  endtask
  task automatic set_pol(input logic p);
    @(posedge clk_in);
    #1 out_cfg_out[OCFG_LOS_POL_BIT] = p;
  endtask
endmodule

/* tb/drm_ctrl_tb.sv */
// self-checking bench for the data-rate measurement block
`timescale 1ns/100ps
module drm_ctrl_tb
  import drm_pkg::*;
;
  logic                clk_in, rst_n_in, rec_clk_in, lock_lost, lsb, los_det;
  logic [REG_W-1:0]    rcfg, act, ocfg, code, aux;
  logic                done, rvalid, cvalid, signal_absent, acq;
  drm_count_t          cnt;
  logic [COARSE_W-1:0] coarse;
  logic [COUNT_W-1:0]  held;
  int                  miscompares, check_count, cyc, n, a;
  int                  exp_q[$];

  drm_host_model drm_host_model_inst (.clk_in(clk_in), .rate_cfg_out(rcfg),
    .action_out(act), .out_cfg_out(ocfg));
  drm_ctrl #(.WIN_BASE_LOG2(4)) drm_ctrl_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .rec_clk_in(rec_clk_in), .rate_config_reg_in(rcfg),
    .action_reg_in(act), .output_config_reg_in(ocfg), .lock_lost_in(lock_lost),
    .rate_code_in(code), .rate_code_lsb_in(lsb), .signal_absent_det_in(los_det),
    .meas_done_out(done), .rate_count_out(cnt), .rate_valid_out(rvalid),
    .coarse_code_out(coarse), .coarse_valid_out(cvalid), .aux_status_out(aux),
    .signal_absent_out(signal_absent), .acq_restart_out(acq));

  initial begin
    clk_in = 0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    rec_clk_in = 0;
    #1.3;
    forever #3 rec_clk_in = ~rec_clk_in;
  end

  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t value %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_near(input logic [31:0] got, input int exp);
    check_count++;
    if ($isunknown(got) || got > exp + 2 || got + 2 < exp) begin
      miscompares++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic measure(input int r);
    drm_host_model_inst.set_cfg(r[1:0], 1'b1);
    // recovered 6 ns edges over 2^(4+r) cycles of 4 ns
    exp_q.push_back((2 ** (4 + r)) * 4 / 6);
    drm_host_model_inst.pulse(ACT_MEAS_RESTART_BIT);
    n = 0;
    a = 0;
    tick(2);
    check_eq(done, 0);
    while (done !== 1'b1 && n < 300) begin
      tick(1);
      n++;
      if (acq === 1'b1) a++;
    end
    check_eq(n < 300, 1);
    check_eq(a, 0);
    tick(1);
    check_eq({rvalid, aux[AUX_DONE_BIT]}, 2'h3);
    held = cnt;
    tick(20);
    check_eq(cnt, held);
    lock_lost = 1;
    tick(2);
    check_eq({rvalid, aux[AUX_DONE_BIT]}, 2'h1);
    lock_lost = 0;
  endtask

  // result arrives with the rising done flag
  always @(posedge done) begin
    #1;
    if (exp_q.size() == 0) check_eq(1, 0);
    else check_near(cnt, exp_q.pop_front());
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(26));
    rst_n_in = 0;
    lock_lost = 0;
    lsb = 0;
    los_det = 0;
    code = 8'h00;
    repeat (2) @(posedge clk_in);
    #1 check_eq({done, cnt}, 0);
    check_eq({coarse, aux, signal_absent, acq}, 0);
    rst_n_in = 1;
    tick(4);
    for (int i = 0; i < 4; i++) begin
      los_det = i[0];
      drm_host_model_inst.set_pol(i[1]);
      tick(5);
      check_eq(signal_absent, i[0] ^ i[1]);
    end
    for (int i = 0; i < 4; i++) begin
      {code, lsb} = 9'($urandom);
      lock_lost = 0;
      tick(2);
      check_eq({cvalid, coarse, aux[0]}, {1'b1, code, lsb, lsb});
      lock_lost = 1;
      {code, lsb} = ~{code, lsb};
      tick(2);
      check_eq({cvalid, coarse}, {1'b0, ~{code, lsb}});
    end
    lock_lost = 0;
    drm_host_model_inst.pulse(ACT_ACQ_RESTART_BIT);
    n = 0;
    repeat (4) begin
      tick(1);
      if (acq === 1'b1) n++;
    end
    check_eq(n, 1);
    for (int r = 0; r < 4; r++) measure(r);
    // restart while disabled clears done but runs no window
    drm_host_model_inst.set_cfg(2'h0, 1'b0);
    drm_host_model_inst.pulse(ACT_MEAS_RESTART_BIT);
    tick(40);
    check_eq({done, cnt}, {1'b0, held});
    give_verdict();
  end
endmodule
